// >>> clkcfg_defs.svh
`ifndef CLKCFG_DEFS_SVH
`define CLKCFG_DEFS_SVH

// register byte addresses
`define RUN_CFG_ADDR 12'h060
`define SECOND_CFG_ADDR 12'h070
`define STATUS_ADDR 12'h074
`define PLL_CHECK_ADDR 12'h078

// run configuration fields
`define RUN_CFG_RESET 32'h078e_3ac0
// bits 21 and 16:14 stay out of the mask so they always read zero
`define RUN_CFG_RW_MASK 32'h0fde_3fff
`define F_SYSTEM_DIVISOR_HI 26
`define F_SYSTEM_DIVISOR_LO 23
`define F_SYSTEM_DIVISOR_EN 22
`define F_PWM_CLOCK_DIVISOR_EN 20
`define F_PWM_CLOCK_DIVISOR_HI 19
`define F_PWM_CLOCK_DIVISOR_LO 17
`define F_PWR_OFF 13
`define F_OUT_N 12
`define F_BYPASS 11
`define F_PLL_CHECK 10

// second configuration fields
`define SECOND_CFG_RESET 32'h0780_0000
`define SECOND_CFG_RW_MASK 32'h8780_0000
`define F_OVERRIDE 31
`define F_ALTDIV_HI 26
`define F_ALTDIV_LO 23

// pll check timeout: ten microseconds of no pll activity
`define PLL_CHECK_NS 10000
`define CLK_PERIOD_NS 5
`define PLL_CHECK_CYCLES (`PLL_CHECK_NS / `CLK_PERIOD_NS)

`endif

// >>> clkcfg_pkg.sv
package clkcfg_pkg;
   // decoded clock selections handed from the register file to the dividers
   typedef struct packed {
      logic [3:0] divisor;
      logic use_divider;
      logic bypass;
   } sys_sel_s;

   typedef struct packed {
      logic [2:0] divisor;
      logic use_divider;
   } pwm_sel_s;

   typedef enum logic [1:0] {
      ahb_idle,
      ahb_write,
      ahb_read
   } bus_phase_e;
endpackage

// >>> pow2_divider.sv
// power-of-two clock enable divider, edges locked to hclk
module pow2_divider (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] log2_ratio,
   output logic tick
);
   logic [5:0] count;
   logic [5:0] next_count;
   logic next_tick;
   logic [5:0] wrap;

   // ratio 2^(n+1) for n up to 5, 64 for n of 5 to 7, one hclk high per period, so no phase offset
   always_comb begin
      wrap = 6'h3f >> (3'd5 - ((log2_ratio > 3'd4) ? 3'd5 : log2_ratio));
      // ratio used live each cycle: a smaller new ratio can cut the current period short
      next_count = (count >= wrap) ? 6'h00 : count + 6'h01;
      next_tick = (count >= wrap);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 6'h00;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule // pow2_divider

// >>> pll_sysclk_pwmclk_config.sv
// Function
// - divider enable routes system clock through system divider
// - pll selected forces system divider use
// - override bit selects second register's divisor field
// - pwm divider enable sources pwm clock from pwm divider
// - pwm divisor codes 0..4 give /2../32, codes 5..7 give /64
// - pwm divided clock power-of-two, rising edges on hclk edges
// - reserved bits read zero, ignore writes; software preserves them
// - power-off bit drives pll power-down input, resets to one
// - output-drive-n bit gates pll clock out, resets to one
// - bypass selects oscillator; cleared selects divided pll
// - check bit runs pll timer, flags pll stop; clear disables
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`include "clkcfg_defs.svh"
module pll_sysclk_pwmclk_config (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic pll_alive,
   output logic pll_power_off,
   output logic pll_out_drive_n,
   output logic sysclk_from_pll,
   output logic sysclk_divided,
   output logic [3:0] sysclk_divisor,
   output logic sysclk_tick,
   output logic pwmclk_tick,
   output logic pll_fail_irq
);
   localparam logic [15:0] CHECK_CYCLES = 16'(`PLL_CHECK_CYCLES);

   // ==========================================================
   // ahb-lite slave
   // ==========================================================
   clkcfg_pkg::bus_phase_e phase;
   clkcfg_pkg::bus_phase_e next_phase;
   logic [11:0] addr_q;
   logic [11:0] next_addr_q;
   logic [31:0] run_clock_configuration;
   logic [31:0] next_run_cfg;
   logic [31:0] second_clock_configuration;
   logic [31:0] next_second_cfg;
   logic [31:0] next_hrdata;
   logic pll_fail;
   logic next_pll_fail;
   logic fail_clear;
   logic [31:0] rd_mux;

   // register read view; reserved bits come back zero
   always_comb begin
      case (addr_q)
         `RUN_CFG_ADDR: rd_mux = run_clock_configuration;
         `SECOND_CFG_ADDR: rd_mux = second_clock_configuration;
         `STATUS_ADDR: rd_mux = {30'h0000_0000, sysclk_from_pll, pll_fail};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // address phase captured, data phase handled next cycle, zero wait for writes, one wait cycle for reads
   always_comb begin
      next_phase = clkcfg_pkg::ahb_idle;
      next_addr_q = addr_q;
      next_run_cfg = run_clock_configuration;
      next_second_cfg = second_clock_configuration;
      next_hrdata = hrdata;
      fail_clear = 1'b0;
      if (phase == clkcfg_pkg::ahb_write) begin
         case (addr_q)
            `RUN_CFG_ADDR: next_run_cfg = hwdata & `RUN_CFG_RW_MASK;
            `SECOND_CFG_ADDR: next_second_cfg = hwdata & `SECOND_CFG_RW_MASK;
            `STATUS_ADDR: fail_clear = hwdata[0]; // write one to clear
            default: ;
         endcase
      end
      if (hsel && hready && htrans[1]) begin
         next_addr_q = haddr[11:0];
         next_phase = hwrite ? clkcfg_pkg::ahb_write : clkcfg_pkg::ahb_read;
         if (!hwrite) begin
            next_hrdata = 32'h0000_0000;
         end
      end
      if (phase == clkcfg_pkg::ahb_read) begin
         next_hrdata = rd_mux;
      end
   end

   // read data lands two cycles after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= clkcfg_pkg::ahb_idle;
         addr_q <= 12'h000;
         run_clock_configuration <= `RUN_CFG_RESET;
         second_clock_configuration <= `SECOND_CFG_RESET;
      end else begin
         phase <= next_phase;
         addr_q <= next_addr_q;
         run_clock_configuration <= next_run_cfg;
         second_clock_configuration <= next_second_cfg;
      end
   end

   // hrdata is combinational from registered state would break the
   // flop-output style, so the read is presented from rd_mux registered
   // below with the data phase extended by one wait cycle
   logic rd_wait;
   logic next_rd_wait;
   always_comb begin
      next_rd_wait = (phase == clkcfg_pkg::ahb_read) && !rd_wait;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait <= 1'b0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         rd_wait <= next_rd_wait;
         hrdata <= next_hrdata;
         hreadyout <= !(next_phase == clkcfg_pkg::ahb_read);
         hresp <= 1'b0;
      end
   end

   // ==========================================================
   // clock selection decode
   // ==========================================================
   clkcfg_pkg::sys_sel_s sys_sel;
   clkcfg_pkg::pwm_sel_s pwm_sel;

   always_comb begin
      sys_sel.bypass = run_clock_configuration[`F_BYPASS];
      sys_sel.use_divider = run_clock_configuration[`F_SYSTEM_DIVISOR_EN]
                            | ~run_clock_configuration[`F_BYPASS];
      sys_sel.divisor = second_clock_configuration[`F_OVERRIDE]
         ? second_clock_configuration[`F_ALTDIV_HI:`F_ALTDIV_LO]
         : run_clock_configuration[`F_SYSTEM_DIVISOR_HI:`F_SYSTEM_DIVISOR_LO];
      pwm_sel.use_divider = run_clock_configuration[`F_PWM_CLOCK_DIVISOR_EN];
      pwm_sel.divisor = run_clock_configuration[`F_PWM_CLOCK_DIVISOR_HI:`F_PWM_CLOCK_DIVISOR_LO];
   end

   // ==========================================================
   // system clock enable divider, divide by divisor+1
   // ==========================================================
   logic [3:0] sys_count;
   logic [3:0] next_sys_count;
   logic next_sys_tick;

   // count compares against the live divisor, so a smaller new divisor can make a runt
   always_comb begin
      if (!sys_sel.use_divider || sys_count >= sys_sel.divisor) begin
         next_sys_count = 4'h0;
         next_sys_tick = 1'b1;
      end else begin
         next_sys_count = sys_count + 4'h1;
         next_sys_tick = 1'b0;
      end
   end

   // ==========================================================
   // pwm clock enable, power-of-two from hclk, not from system ticks
   // ==========================================================
   logic pwm_div_tick;
   logic next_pwm_tick;

   pow2_divider u_pwm_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .log2_ratio(pwm_sel.divisor),
      .tick(pwm_div_tick)
   );

   // undivided pwm clock follows hclk; divided one is the aligned pulse
   always_comb begin
      next_pwm_tick = pwm_sel.use_divider ? pwm_div_tick : 1'b1;
   end

   // ==========================================================
   // pll control pins and selection outputs
   // ==========================================================
   logic pll_alive_s1;
   logic pll_alive_s2;
   logic pll_alive_s3;
   logic [15:0] check_count;
   logic [15:0] next_check_count;
   logic alive_edge;

   // timer restarts on every pll activity edge; expiry flags failure
   always_comb begin
      alive_edge = pll_alive_s2 ^ pll_alive_s3;
      next_check_count = check_count;
      next_pll_fail = pll_fail;
      if (!run_clock_configuration[`F_PLL_CHECK] || alive_edge) begin
         next_check_count = 16'h0000;
      end else if (check_count < CHECK_CYCLES) begin
         next_check_count = check_count + 16'h0001;
      end
      if (fail_clear) begin
         next_pll_fail = 1'b0;
      end
      if (run_clock_configuration[`F_PLL_CHECK]
          && check_count == CHECK_CYCLES - 16'h0001) begin
         next_pll_fail = 1'b1; // set wins over clear
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_count <= 4'h0;
         sysclk_tick <= 1'b0;
         pwmclk_tick <= 1'b0;
         pll_power_off <= 1'b1;
         pll_out_drive_n <= 1'b1;
         sysclk_from_pll <= 1'b0;
         sysclk_divided <= 1'b0;
         sysclk_divisor <= 4'h0;
         pll_alive_s1 <= 1'b0;
         pll_alive_s2 <= 1'b0;
         pll_alive_s3 <= 1'b0;
         check_count <= 16'h0000;
         pll_fail <= 1'b0;
         pll_fail_irq <= 1'b0;
      end else begin
         sys_count <= next_sys_count;
         sysclk_tick <= next_sys_tick;
         pwmclk_tick <= next_pwm_tick;
         pll_power_off <= run_clock_configuration[`F_PWR_OFF];
         pll_out_drive_n <= run_clock_configuration[`F_OUT_N];
         sysclk_from_pll <= ~sys_sel.bypass;
         sysclk_divided <= sys_sel.use_divider;
         sysclk_divisor <= sys_sel.divisor;
         pll_alive_s1 <= pll_alive;
         pll_alive_s2 <= pll_alive_s1;
         pll_alive_s3 <= pll_alive_s2;
         check_count <= next_check_count;
         pll_fail <= next_pll_fail;
         pll_fail_irq <= next_pll_fail;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   sequence run_write_seq;
      phase == clkcfg_pkg::ahb_write && addr_q == `RUN_CFG_ADDR;
   endsequence

   a_reserved_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      run_clock_configuration[21] == 1'b0
      && run_clock_configuration[16:14] == 3'b000)
      else $error("reserved bits not zero");

   a_power_pin: assert property (
      @(posedge hclk) disable iff (!hresetn)
      run_write_seq ##2 1'b1 |-> pll_power_off == $past(hwdata[13], 2))
      else $error("power-off pin does not follow register");

   a_drive_pin: assert property (
      @(posedge hclk) disable iff (!hresetn)
      run_write_seq ##2 1'b1 |-> pll_out_drive_n == $past(hwdata[12], 2))
      else $error("drive pin does not follow register");

   a_pll_forces_div: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sysclk_from_pll |-> sysclk_divided)
      else $error("pll selected without divider");

   a_div_enable: assert property (
      @(posedge hclk) disable iff (!hresetn)
      run_clock_configuration[22] |=> sysclk_divided)
      else $error("divider enable ignored");

   a_override_div: assert property (
      @(posedge hclk) disable iff (!hresetn)
      second_clock_configuration[31] |=> sysclk_divisor
         == $past(second_clock_configuration[26:23]))
      else $error("override divisor not used");

   a_pwm_undivided: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !run_clock_configuration[20] [*2] |-> pwmclk_tick)
      else $error("undivided pwm clock not every cycle");

   a_pwm_spacing: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(pwm_div_tick) && run_clock_configuration[19:17] == 3'h0
      && $stable(run_clock_configuration) |=> !pwm_div_tick ##1 pwm_div_tick)
      else $error("pwm divide by two wrong");

   a_check_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !run_clock_configuration[10] |=> check_count == 16'h0000)
      else $error("check timer runs while disabled");

   // a selection written on the tick edge may legally tick again at once
   a_sys_no_runt: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sysclk_tick && sys_sel.use_divider && sys_sel.divisor != 4'h0
      |=> $changed(sys_sel) || !sysclk_tick)
      else $error("system clock runt pulse");
endmodule // pll_sysclk_pwmclk_config

// >>> test_pll_sysclk_pwmclk_config.sv
`include "clkcfg_defs.svh"
module test_pll_sysclk_pwmclk_config;
   timeunit 1ns;
   timeprecision 1ps;
   // reserved 31:28, 21 and 16:14 never hold a written one
   localparam logic [31:0] RUN_MASK = 32'h0fde_3fff;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic pll_alive = 1'b0;
   logic alive_run = 1'b0;
   logic pll_power_off;
   logic pll_out_drive_n;
   logic sysclk_from_pll;
   logic sysclk_divided;
   logic [3:0] sysclk_divisor;
   logic sysclk_tick;
   logic pwmclk_tick;
   logic pll_fail_irq;
   logic [31:0] exp_q[$];
   logic [31:0] rd_got;
   logic [31:0] run_val;
   logic [31:0] sec_val;
   event rd_ev;
   int fail_count = 0;
   int n_compared = 0;
   int per;

   // ==========================================================
   // clocking, design and helpers
   assign hready = hreadyout;
   always #2.5 hclk = ~hclk;
   // pll activity: toggles only while the pll is meant to run
   always @(posedge hclk) if (alive_run) pll_alive <= ~pll_alive;

   pll_sysclk_pwmclk_config dut_u (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pll_alive(pll_alive),
      .pll_power_off(pll_power_off), .pll_out_drive_n(pll_out_drive_n),
      .sysclk_from_pll(sysclk_from_pll), .sysclk_divided(sysclk_divided),
      .sysclk_divisor(sysclk_divisor), .sysclk_tick(sysclk_tick),
      .pwmclk_tick(pwmclk_tick), .pll_fail_irq(pll_fail_irq));

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_reg({31'h0, got}, {31'h0, exp});
   endtask

   // read results arrive in issue order, so the oldest note matches
   always @(rd_ev) begin
      if (exp_q.size() == 0)
         cmp_reg(rd_got, 32'hdead_beef);
      else
         cmp_reg(rd_got, exp_q.pop_front());
   end

   // ==========================================================
   // bus master
   // bounded wait: a stuck slave ends the run instead of hanging
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         fail_count++;
         end_sim();
      end
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      cmp_bit(hresp, 1'b0);
      if (!wr) begin
         rd_got = hrdata;
         -> rd_ev;
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask

   // pins follow the register one cycle after the write lands
   task automatic chk_pins(input logic [31:0] r, input logic [31:0] s);
      repeat (2) @(posedge hclk);
      #1;
      cmp_bit(pll_power_off, r[13]);
      cmp_bit(pll_out_drive_n, r[12]);
      cmp_bit(sysclk_from_pll, ~r[11]);
      cmp_bit(sysclk_divided, r[22] | ~r[11]);
      cmp_reg({28'h0, sysclk_divisor},
              {28'h0, s[31] ? s[26:23] : r[26:23]});
      @(posedge hclk);
   endtask

   // first pass finds a tick, second counts cycles to the next one
   task automatic tick_period(input logic pwm, output int p);
      p = 0;
      for (int i = 0; i < 2; i++) begin
         p = 0;
         do begin
            @(posedge hclk);
            #1;
            p++;
         end while ((pwm ? pwmclk_tick : sysclk_tick) !== 1'b1 && p < 200);
      end
      @(posedge hclk);
   endtask

   // ==========================================================
   // watchdog and main sequence
   initial begin
      repeat (40000) @(posedge hclk);
      fail_count++;
      end_sim();
   end

   initial begin
      void'($urandom(92019));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`RUN_CFG_ADDR, `RUN_CFG_RESET);
      rd(`SECOND_CFG_ADDR, `SECOND_CFG_RESET);
      wr(`PLL_CHECK_ADDR, 32'hffff_ffff);
      rd(`PLL_CHECK_ADDR, 32'h0000_0000);
      chk_pins(`RUN_CFG_RESET, `SECOND_CFG_RESET);
      // random configs, pll check kept off so no failure latches
      for (int i = 0; i < 12; i++) begin
         run_val = $urandom & 32'hffff_fbff;
         sec_val = $urandom;
         wr(`RUN_CFG_ADDR, run_val);
         wr(`SECOND_CFG_ADDR, sec_val);
         rd(`RUN_CFG_ADDR, run_val & RUN_MASK);
         rd(`SECOND_CFG_ADDR, sec_val & 32'h8780_0000);
         chk_pins(run_val, sec_val);
      end
      // every pwm code, then the divider bypassed
      for (int c = 0; c < 8; c++) begin
         run_val = (`RUN_CFG_RESET & 32'hfff1_ffff) | 32'h0010_0000;
         wr(`RUN_CFG_ADDR, run_val | (32'(c) << 17));
         tick_period(1'b1, per);
         cmp_reg(32'(per),
                 c >= 5 ? 32'h0000_0040 : 32'h0000_0002 << c);
      end
      wr(`RUN_CFG_ADDR, `RUN_CFG_RESET);
      tick_period(1'b1, per);
      cmp_reg(32'(per), 32'h0000_0001);
      // system divider: forced by pll, enabled, off, overridden
      wr(`SECOND_CFG_ADDR, 32'h0000_0000);
      // pll selected, so the system clock comes from the pll
      wr(`RUN_CFG_ADDR, 32'h0180_0000);
      tick_period(1'b0, per);
      cmp_reg(32'(per), 32'h0000_0004);
      wr(`RUN_CFG_ADDR, 32'h02c0_0800);
      tick_period(1'b0, per);
      cmp_reg(32'(per), 32'h0000_0006);
      wr(`RUN_CFG_ADDR, 32'h0280_0800);
      tick_period(1'b0, per);
      cmp_reg(32'(per), 32'h0000_0001);
      wr(`SECOND_CFG_ADDR, 32'h8100_0000);
      wr(`RUN_CFG_ADDR, 32'h0280_0000);
      tick_period(1'b0, per);
      cmp_reg(32'(per), 32'h0000_0003);
      // pll check: off stays quiet, on with a dead pll flags
      wr(`RUN_CFG_ADDR, `RUN_CFG_RESET);
      wr(`STATUS_ADDR, 32'h0000_0001);
      repeat (2100) @(posedge hclk);
      #1;
      cmp_bit(pll_fail_irq, 1'b0);
      @(posedge hclk);
      wr(`RUN_CFG_ADDR, `RUN_CFG_RESET | 32'h0000_0400);
      repeat (2100) @(posedge hclk);
      #1;
      cmp_bit(pll_fail_irq, 1'b1);
      @(posedge hclk);
      rd(`STATUS_ADDR, 32'h0000_0001);
      // power the pll up and let its clock out before it is expected to run
      wr(`RUN_CFG_ADDR, `RUN_CFG_RESET & 32'hffff_cfff | 32'h0000_0400);
      repeat (2) @(posedge hclk);
      #1;
      cmp_bit(pll_power_off | pll_out_drive_n, 1'b0);
      alive_run <= 1'b1;
      repeat (10) @(posedge hclk);
      wr(`STATUS_ADDR, 32'h0000_0001);
      repeat (2100) @(posedge hclk);
      #1;
      cmp_bit(pll_fail_irq, 1'b0);
      @(posedge hclk);
      rd(`STATUS_ADDR, 32'h0000_0000);
      repeat (4) @(posedge hclk);
      end_sim();
   end
endmodule // test_pll_sysclk_pwmclk_config
